//--- rtl/eip_regs.vh
// Register map, field positions, reset values and timing counts of the
// identification emulation and protection policy block.
// Assumes APB with 32-bit data and a 10 MHz pclk.
`ifndef EIP_REGS_VH
`define EIP_REGS_VH

`define EIP_OFS_CTRL      12'h000
`define EIP_OFS_STATUS    12'h004
`define EIP_OFS_EMU_ADDR  12'h008
`define EIP_OFS_EMU_DATA  12'h00C
`define EIP_OFS_SNK_ADDR  12'h010
`define EIP_OFS_SNK_DATA  12'h014
`define EIP_OFS_POLICY    12'h018
`define EIP_OFS_SNK_CTRL  12'h01C

// CTRL fields
`define EIP_CTRL_DYN      0
`define EIP_CTRL_INPROT   1
`define EIP_CTRL_IN14     2
`define EIP_CTRL_OUTAUTO  3
`define EIP_CTRL_COMMIT   4
`define EIP_CTRL_RESET    32'h0000_0002

// STATUS / POLICY fields
`define EIP_LVL_NONE      2'h0
`define EIP_LVL_V14       2'h1
`define EIP_LVL_V22       2'h2
`define EIP_LVL_RED       2'h3

`define EIP_EDID_BYTES    256
`define EIP_BASE_BYTES    128

`define EIP_PULSE_MS      2000
`define EIP_CLK_KHZ       10000
`define EIP_PULSE_CYC     (`EIP_PULSE_MS * `EIP_CLK_KHZ)

`endif

//--- rtl/eip_core.v
// One input's identification emulation and output protection policy.
// Assumes a sink store kept alive by the surrounding power domain (battery-
// backed RAM), and sink, stream and video status from link logic on pclk.
// How it works
// - Base identification block is 128 bytes.
// - Optional 128-byte extension block also emulated.
// - Sink identification kept in persistent store.
// - Static or dynamic source selectable per input.
// - Dynamic follow only on valid new sink.
// - Each input has its own circuit.
// - Replace identification while source stays connected.
// - Drop presence line during change, release it 2 seconds after.
// - Never encrypt toward incapable sink; red instead.
// - Disabled input reports no protection capability.
// - Auto output, disabled input: send unencrypted.
// - Encrypt only while video is active.
// - Topology limits 32 and 128 devices, four levels, checked for encrypted input only.
// - Capable sink of newest version gets newest version.
// - Type 0 newer input to older sink: older.
// - Type 1 newer input to older sink: red.
// - Downgrade by advertising older version on input.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "eip_regs.vh"
module eip_core #(
   parameter integer PULSE_CYC = `EIP_PULSE_CYC,
   parameter integer MAX_DEPTH = 4,
   parameter integer MAX_DEV14 = 128,
   parameter integer MAX_DEV22 = 32
) (
   input  wire        pclk,            // APB clock, 10 MHz
   input  wire        presetn,         // Async reset, active low
   input  wire        psel,            // APB select
   input  wire        penable,         // APB enable
   input  wire        pwrite,          // APB direction
   input  wire [11:0] paddr,           // APB byte address
   input  wire [31:0] pwdata,          // APB write data
   output reg  [31:0] prdata,          // APB read data
   output reg         pready,          // APB ready
   output reg         pslverr,         // APB error
   input  wire [7:0]  ddc_addr,        // Source read offset, 0..255
   output reg  [7:0]  ddc_data,        // Emulated byte for source
   output reg         sink_presence_line, // Presence toward source
   output reg         in_prot_capable, // Advertised capability
   output reg         in_adv_v22,      // Advertised newest version
   input  wire        snk_attach,      // Output sink attached, async
   input  wire        snk_valid,       // Sink identification valid, async
   input  wire        snk_wr,          // Sink byte write strobe
   input  wire [7:0]  snk_waddr,       // Sink byte offset
   input  wire [7:0]  snk_wdata,       // Sink byte
   input  wire        snk_v14,         // Sink supports older version
   input  wire        snk_v22,         // Sink supports newest version
   input  wire        in_encrypted,    // Input stream encrypted
   input  wire        in_is_v22,       // Input uses newest version
   input  wire        in_stream_type,  // Stream type, 1 = no convert
   input  wire        video_active,    // Active video present
   input  wire [7:0]  topo_devices,    // Downstream device count
   input  wire [2:0]  topo_depth,      // Repeater levels crossed
   output reg  [1:0]  out_level,       // Output encryption level
   output reg         out_blank        // Red screen / mute
);
   // Per-input stores: emulated, user static, and persistent sink copy
   reg [7:0] emu_mem [0:`EIP_EDID_BYTES-1];
   reg [7:0] stat_mem [0:`EIP_EDID_BYTES-1];
   reg [7:0] snk_mem [0:`EIP_EDID_BYTES-1];

   reg        dyn_r;
   reg        inprot_r;
   reg        in14_r;
   reg        outauto_r;
   reg [7:0]  emu_addr_r;
   reg [7:0]  snk_addr_r;
   reg        copy_busy_r;
   reg        copy_src_r;
   reg        sink_have_r;
   reg [7:0]  copy_idx_r;
   reg [31:0] pulse_cnt_r;
   reg [2:0]  att_s;
   reg [2:0]  val_s;
   reg        att_d_r;
   reg [7:0]  snk_rd;

   wire        acc        = psel & penable & pready;
   wire        wr         = acc & pwrite;
   wire        setup      = psel & ~penable;
   wire        mapped     = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
   wire        att_q      = (att_s[2] == att_s[1]) ? att_s[1] : att_d_r;
   wire        val_q      = val_s[1] & val_s[2];
   wire        new_sink   = att_q & ~att_d_r;
   wire        commit     = wr && (paddr == `EIP_OFS_CTRL) && pwdata[`EIP_CTRL_COMMIT];
   wire        auto_copy  = dyn_r && new_sink && val_q;
   wire        pulsing    = (pulse_cnt_r != 32'h0);
   wire        depth_over = (topo_depth > MAX_DEPTH);
   wire [31:0] status_word;
   wire [31:0] policy_word;

   // Status bits, one per line so the map stays readable
   assign status_word[0]     = video_active;
   assign status_word[1]     = snk_v14;
   assign status_word[2]     = snk_v22;
   assign status_word[3]     = att_q;
   assign status_word[4]     = val_q;
   assign status_word[5]     = pulsing;
   assign status_word[6]     = copy_busy_r;
   assign status_word[7]     = sink_have_r;
   assign status_word[9:8]   = out_level;
   assign status_word[10]    = out_blank;
   assign status_word[11]    = depth_over;
   assign status_word[31:12] = 20'h00000;

   // Policy view: advertised capability, chosen level, topology size
   assign policy_word[7:0]   = topo_devices;
   assign policy_word[9:8]   = out_level;
   assign policy_word[10]    = in_adv_v22;
   assign policy_word[11]    = in_prot_capable;
   assign policy_word[31:12] = 20'h00000;

   always @(posedge pclk) begin
      if (snk_wr) begin
         snk_mem[snk_waddr] <= snk_wdata;
      end
      if (wr && paddr == `EIP_OFS_EMU_DATA) begin
         stat_mem[emu_addr_r] <= pwdata[7:0];
      end
      if (copy_busy_r) begin
         emu_mem[copy_idx_r] <= copy_src_r ? snk_mem[copy_idx_r] : stat_mem[copy_idx_r];
      end
      ddc_data <= emu_mem[ddc_addr];
      snk_rd   <= snk_mem[snk_addr_r];
   end

   // Attach and valid cross from the sink side through three flops
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         att_s   <= 3'h0;
         val_s   <= 3'h0;
         att_d_r <= 1'b0;
      end else begin
         att_s   <= {att_s[1:0], snk_attach};
         val_s   <= {val_s[1:0], snk_valid};
         att_d_r <= att_q;
      end
   end

   // One access cycle: the answer stands in the cycle after setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         prdata  <= 32'h0;
         if (setup && !pwrite) begin
            case (paddr)
               `EIP_OFS_CTRL:     prdata <= {28'h0, outauto_r, in14_r, inprot_r, dyn_r};
               `EIP_OFS_STATUS:   prdata <= status_word;
               `EIP_OFS_EMU_ADDR: prdata <= {24'h0, emu_addr_r};
               `EIP_OFS_SNK_ADDR: prdata <= {24'h0, snk_addr_r};
               `EIP_OFS_SNK_DATA: prdata <= {24'h0, snk_rd};
               `EIP_OFS_POLICY:   prdata <= policy_word;
               default:           prdata <= 32'h0;
            endcase
         end
      end
   end

   // Control and address registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dyn_r      <= 1'b0;
         inprot_r   <= 1'b1;
         in14_r     <= 1'b0;
         outauto_r  <= 1'b0;
         emu_addr_r <= 8'h00;
         snk_addr_r <= 8'h00;
      end else if (wr) begin
         case (paddr)
            `EIP_OFS_CTRL: begin
               dyn_r     <= pwdata[`EIP_CTRL_DYN];
               inprot_r  <= pwdata[`EIP_CTRL_INPROT];
               in14_r    <= pwdata[`EIP_CTRL_IN14];
               outauto_r <= pwdata[`EIP_CTRL_OUTAUTO];
            end
            `EIP_OFS_EMU_ADDR: emu_addr_r <= pwdata[7:0];
            `EIP_OFS_EMU_DATA: emu_addr_r <= emu_addr_r + 8'h01;
            `EIP_OFS_SNK_ADDR: snk_addr_r <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // Copy engine: one byte a cycle, then the presence line stays low
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         copy_busy_r <= 1'b0;
         copy_src_r  <= 1'b0;
         copy_idx_r  <= 8'h00;
         pulse_cnt_r <= 32'h0;
      end else if (!copy_busy_r && commit) begin
         copy_busy_r <= 1'b1;
         copy_src_r  <= pwdata[`EIP_CTRL_DYN];
         copy_idx_r  <= 8'h00;
      end else if (!copy_busy_r && auto_copy) begin
         copy_busy_r <= 1'b1;
         copy_src_r  <= 1'b1;
         copy_idx_r  <= 8'h00;
      end else if (copy_busy_r) begin
         copy_idx_r <= copy_idx_r + 8'h01;
         if (copy_idx_r == 8'hFF) begin
            copy_busy_r <= 1'b0;
            pulse_cnt_r <= PULSE_CYC;
         end
      end else if (pulsing) begin
         pulse_cnt_r <= pulse_cnt_r - 32'h1;
      end
   end

   // Presence toward the source and the stored-sink flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sink_have_r        <= 1'b0;
         sink_presence_line <= 1'b0;
      end else begin
         if (new_sink && val_q) begin
            sink_have_r <= 1'b1;
         end
         sink_presence_line <= !pulsing && !copy_busy_r;
      end
   end

   // Output protection policy, re-evaluated every cycle from live inputs
   reg [1:0] lvl_nxt;
   reg       blank_nxt;
   always @* begin
      lvl_nxt = `EIP_LVL_NONE;
      blank_nxt = 1'b0;
      if (!video_active) begin
         lvl_nxt = `EIP_LVL_NONE;
      end else if (!in_encrypted && (outauto_r || !inprot_r)) begin
         lvl_nxt = `EIP_LVL_NONE;
      end else if (!in_encrypted && !outauto_r && !snk_v14 && !snk_v22) begin
         lvl_nxt = `EIP_LVL_NONE;
      end else if (snk_v22) begin
         lvl_nxt = `EIP_LVL_V22;
      end else if (snk_v14 && (!in_is_v22 || !in_stream_type)) begin
         lvl_nxt = `EIP_LVL_V14;
      end else begin
         lvl_nxt = `EIP_LVL_RED;
         blank_nxt = 1'b1;
      end
      if (in_encrypted && ((topo_depth > MAX_DEPTH) ||
          (lvl_nxt == `EIP_LVL_V22 && topo_devices > MAX_DEV22) ||
          (lvl_nxt == `EIP_LVL_V14 && topo_devices > MAX_DEV14))) begin
         lvl_nxt = `EIP_LVL_RED;
         blank_nxt = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_level <= `EIP_LVL_NONE;
         out_blank <= 1'b0;
         in_prot_capable <= 1'b0;
         in_adv_v22 <= 1'b0;
      end else begin
         out_level <= lvl_nxt;
         out_blank <= blank_nxt;
         in_prot_capable <= inprot_r;
         in_adv_v22 <= inprot_r & ~in14_r;
      end
   end
endmodule
`default_nettype wire

//--- sim/eip_core_checker.sv
// Concurrent checks on the ports of eip_core, bound to every instance.
// Assumes the pclk domain only and the shortened pulse count of the bench.
`timescale 1ns/1ps
`default_nettype none
`include "eip_regs.vh"
module eip_core_checker #(parameter integer PULSE_CYC = 50) (
   input wire logic        pclk, presetn, psel, penable, pwrite, pready,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        sink_presence_line, in_prot_capable, in_adv_v22, out_blank,
   input wire logic        snk_v14, snk_v22, in_encrypted, in_is_v22, in_stream_type,
   input wire logic        video_active,
   input wire logic [7:0]  topo_devices,
   input wire logic [2:0]  topo_depth,
   input wire logic [1:0]  out_level
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [31:0] low_cnt_r;
   logic        seen_r;
   wire ok22 = topo_depth <= 3'h4 && topo_devices <= 8'h20;
   wire ok14 = topo_depth <= 3'h4 && topo_devices <= 8'h80;
   wire enc  = video_active && in_encrypted;
   // Length of each low stretch of the presence line
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_cnt_r <= 32'h0;
         seen_r <= 1'b0;
      end else begin
         seen_r <= seen_r | sink_presence_line;
         low_cnt_r <= sink_presence_line ? 32'h0 : low_cnt_r + 32'h1;
      end
   end
   sequence ctrl_wr;
      psel && penable && pready && pwrite && paddr == `EIP_OFS_CTRL;
   endsequence
   a_pulse_len: assert property ($rose(sink_presence_line) && seen_r |->
      low_cnt_r >= PULSE_CYC && low_cnt_r <= PULSE_CYC + 300) else $error("bad pulse");
   a_red_blank: assert property (out_blank == (out_level == `EIP_LVL_RED))
      else $error("blank and red disagree");
   a_incap_red: assert property (enc && !snk_v14 && !snk_v22 |=>
      out_level == `EIP_LVL_RED) else $error("encrypted to incapable sink");
   a_no_video: assert property (!video_active |=> out_level != `EIP_LVL_V14 &&
      out_level != `EIP_LVL_V22) else $error("encrypting without video");
   a_v22_sink: assert property (enc && snk_v22 && ok22 |=>
      out_level == `EIP_LVL_V22) else $error("newest sink not served newest");
   a_type0_down: assert property (enc && in_is_v22 && !in_stream_type && snk_v14 &&
      !snk_v22 && ok14 |=> out_level == `EIP_LVL_V14) else $error("no downgrade");
   a_type1_red: assert property (enc && in_is_v22 && in_stream_type && !snk_v22 |=>
      out_level == `EIP_LVL_RED) else $error("type 1 converted");
   a_clear_fwd: assert property (video_active && !in_encrypted && !in_prot_capable &&
      ok22 |=> out_level == `EIP_LVL_NONE) else $error("clear content encrypted");
   a_cap_off: assert property (ctrl_wr ##0 !pwdata[1] |-> ##[1:2]
      !in_prot_capable && !in_adv_v22) else $error("capability still advertised");
   a_adv_old: assert property (ctrl_wr ##0 pwdata[1] && pwdata[2] |-> ##[1:2]
      in_prot_capable && !in_adv_v22) else $error("older version not advertised");
endmodule
bind eip_core eip_core_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (.*);
`default_nettype wire

//--- sim/eip_snk_model.sv
// Output sink model: on go it unplugs, reloads its bytes, then replugs.
// Assumes go is a one-cycle request on pclk; invalid sinks write nothing.
`timescale 1ns/1ps
`default_nettype none
module eip_snk_model (
   input wire logic       pclk, go, id_ok,
   input wire logic [7:0] base,
   output var logic       snk_attach = 0, snk_valid = 0, snk_wr = 0, busy = 0,
   output var logic [7:0] snk_waddr = 0, snk_wdata = 0
);
   always @(posedge pclk) if (go) begin
      busy <= 1;
      snk_attach <= 0;
      snk_valid <= 0;
      repeat (4) @(posedge pclk);
      for (int i = 0; i < 256 && id_ok; i++) begin
         snk_wr <= 1;
         snk_waddr <= i[7:0];
         snk_wdata <= base ^ i[7:0];
         @(posedge pclk);
      end
      snk_wr <= 0;
      snk_wdata <= ~snk_wdata; // Released bus does not keep the last byte
      snk_valid <= id_ok;
      @(posedge pclk);
      snk_attach <= 1;
      busy <= 0;
   end
endmodule
`default_nettype wire

//--- sim/tb_eip_core.sv
// Bench for eip_core: APB master tasks, sink model, policy table.
// Assumes the presence pulse is shortened through PULSE_CYC.
`timescale 1ns/1ps
`default_nettype none
`include "eip_regs.vh"
module tb_eip_core;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, id_ok = 1;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rv;
   logic pready, pslverr, ev, sink_presence_line, in_prot_capable, in_adv_v22, out_blank;
   logic [7:0] ddc_addr = 0, ddc_data, snk_waddr, snk_wdata, base = 0, topo_devices = 0;
   logic snk_attach, snk_valid, snk_wr, busy, snk_v14 = 0, snk_v22 = 0, in_encrypted = 0;
   logic in_is_v22 = 0, in_stream_type = 0, video_active = 0;
   logic [2:0] topo_depth = 0;
   logic [1:0] out_level;
   integer n_mismatch = 0, samples_checked = 0, n;
   // video, encrypted, newest in, type, older sink, newest sink, over limit, level
   localparam logic [8:0] VEC [0:7] = '{9'h191, 9'h19A, 9'h1D1, 9'h1F3,
                                        9'h1FA, 9'h183, 9'h098, 9'h1DF};
   eip_core #(.PULSE_CYC(50)) DUT (.*);
   eip_snk_model u_snk (.*);
   always #50 pclk = ~pclk;
   task check(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s exp %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      ev = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task ddc_chk(input logic [7:0] a, e);
      @(posedge pclk);
      ddc_addr <= a;
      repeat (2) @(posedge pclk);
      #1 check("ddc", {24'h0, ddc_data}, {24'h0, e});
   endtask
   task pulse;
      while (sink_presence_line !== 1'b0) @(posedge pclk);
      while (sink_presence_line !== 1'b1) @(posedge pclk);
   endtask
   task sink_swap(input logic [7:0] b, input logic ok);
      @(posedge pclk);
      base <= b;
      id_ok <= ok;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      @(posedge pclk);
      while (busy) @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #5000000;
      n_mismatch++;
      final_report;
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1;
      apb(0, `EIP_OFS_CTRL, 0);
      check("ctrl", rv, `EIP_CTRL_RESET);
      apb(0, 12'h020, 0);
      check("unmapped", {rv[31:1], rv[0] ^ ev}, 32'h1);
      apb(1, `EIP_OFS_EMU_ADDR, 0);
      for (n = 0; n < 256; n++) apb(1, `EIP_OFS_EMU_DATA, n ^ 32'hA5);
      apb(1, `EIP_OFS_CTRL, 32'h12);
      pulse;
      for (n = 0; n < 256; n += 51) ddc_chk(n[7:0], n[7:0] ^ 8'hA5);
      sink_swap(8'h30, 1);
      apb(1, `EIP_OFS_CTRL, 32'h13);
      pulse;
      for (n = 0; n < 256; n += 51) ddc_chk(n[7:0], n[7:0] ^ 8'h30);
      sink_swap(8'h70, 0);
      check("presence", {31'h0, sink_presence_line}, 32'h1);
      ddc_chk(8'h03, 8'h33);
      sink_swap(8'h70, 1);
      pulse;
      ddc_chk(8'h83, 8'hF3);
      for (n = 0; n < 8; n++) begin
         @(posedge pclk);
         {video_active, in_encrypted, in_is_v22, in_stream_type, snk_v14, snk_v22} <= VEC[n][8:3];
         topo_devices <= VEC[n][2] ? 8'h21 : 8'h20;
         repeat (3) @(posedge pclk);
         #1 check("level", {29'h0, out_blank, out_level}, {29'h0, &VEC[n][1:0], VEC[n][1:0]});
      end
      apb(1, `EIP_OFS_CTRL, 32'h08);
      @(posedge pclk);
      {in_encrypted, snk_v14, snk_v22, topo_devices} <= 11'h000;
      repeat (3) @(posedge pclk);
      #1 check("clear", {29'h0, in_prot_capable, out_level}, 32'h0);
      apb(1, `EIP_OFS_CTRL, 32'h06);
      repeat (3) @(posedge pclk);
      #1 check("advertise", {30'h0, in_prot_capable, in_adv_v22}, 32'h2);
      final_report;
   end
endmodule
`default_nettype wire
